// ### sim/pps_eng_model.sv
// far-side protocol engine and protocol type table for the sequencer bench
// assumes the sequencer's engine handshake on the same single clock
`timescale 1ns/100ps
`default_nettype none

module pps_eng_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] type_num,
	output logic [1:0] type_in,
	input wire logic eng_start,
	input wire logic eng_abort,
	input wire logic [7:0] eng_proto_num,
	output logic eng_done,
	output logic [15:0] eng_err,
	output logic [4:0] eng_match,
	output logic [2:0] eng_phase,
	input wire logic [7:0] lat,
	input wire logic hold,
	input wire logic [7:0] fail_num
);
	logic run;
	logic [7:0] cnt;
	logic [7:0] cur;

	// --------------------------------------------------------
	// type table and live phase
	// --------------------------------------------------------
	// bits 5:4 of the number pick the type: 0 send, 1 receive, else both
	assign type_in = (type_num[5:4] == 2'h0) ? 2'h0 : ((type_num[5:4] == 2'h1) ? 2'h1 : 2'h2);
	assign eng_phase = run ? 3'h3 : 3'h0;

	// --------------------------------------------------------
	// engine run
	// --------------------------------------------------------
	// result lines toggle outside done, so a stale value never looks valid
	always_ff @(posedge aclk) begin
		eng_done <= 1'b0;
		eng_err <= ~eng_err;
		eng_match <= ~eng_match;
		if (!aresetn) begin
			run <= 1'b0;
			cnt <= 8'h00;
			eng_err <= 16'h5A5A;
			eng_match <= 5'h0A;
		end else if (eng_abort) begin
			run <= 1'b0;
		end else if (eng_start) begin
			run <= 1'b1;
			cnt <= lat;
			cur <= eng_proto_num;
		end else if (run && !hold) begin
			cnt <= cnt - 8'h01;
			if (cnt == 8'h00) begin
				run <= 1'b0;
				eng_done <= 1'b1;
				eng_err <= (cur == fail_num) ? 16'hC4A1 : 16'h0000;
				eng_match <= {1'b0, cur[3:0]} + 5'h01;
			end
		end
	end
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench of the protocol chain sequencer
// assumes pps_defs.svh on the include path and the engine model beside it
`timescale 1ns/100ps
`default_nettype none
`include "pps_defs.svh"

module tb_top;
	logic aclk, aresetn, awv, wv, br, arv, rr, scan_end, swd, hold;
	logic awr, wr_r, bv, arr, rv, es, ea, ed, done, errf, busy;
	logic [1:0] bresp, rresp, type_in, cu, rs;
	logic [2:0] eph;
	logic [3:0] ws;
	logic [3:0] sc = 4'h0;
	logic [4:0] econ, em, xcon;
	logic [7:0] type_num, epn, lat, fnum;
	logic [15:0] awa, ara, eerr, lref;
	logic [31:0] wd, rdata, rd;
	logic [7:0] q[$];
	int n_errors, num_checks, aborts;

	pps_sequencer u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
		.s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
		.scan_end(scan_end), .setting_wr_done(swd), .type_num(type_num), .type_in(type_in),
		.eng_start(es), .eng_abort(ea), .eng_proto_num(epn), .eng_conn(econ), .eng_done(ed),
		.eng_err(eerr), .eng_match(em), .eng_phase(eph), .done_flag(done), .err_flag(errf),
		.busy(busy), .legacy_refuse(lref), .conns_used(cu));

	pps_eng_model u_eng (.aclk(aclk), .aresetn(aresetn), .type_num(type_num),
		.type_in(type_in), .eng_start(es), .eng_abort(ea), .eng_proto_num(epn),
		.eng_done(ed), .eng_err(eerr), .eng_match(em), .eng_phase(eph), .lat(lat),
		.hold(hold), .fail_num(fnum));

	// --------------------------------------------------------
	// clock, scan ends, launch monitor
	// --------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// scan end every 16 cycles, so the flag interval is 16 cycles long
	always @(posedge aclk) begin
		sc <= sc + 4'h1;
		scan_end <= (sc == 4'hF);
	end

	// record every launch so order and count can be judged after the run
	always @(posedge aclk) begin
		if (es === 1'b1) begin
			q.push_back(epn);
			chk({27'h0, econ}, {27'h0, xcon});
		end
		if (ea === 1'b1)
			aborts++;
	end

	// --------------------------------------------------------
	// shared tasks
	// --------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// bus write: both channels offered together, each dropped once taken
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		int n;
		n = 0;
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awv && awr)
				awv <= 1'b0;
			if (wv && wr_r)
				wv <= 1'b0;
		end while (bv !== 1'b1 && n < 64);
		rs = bresp;
		br <= 1'b0;
		chk(32'(n < 64), 32'h1);
		@(posedge aclk);
	endtask

	task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
		int n;
		n = 0;
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arv && arr)
				arv <= 1'b0;
		end while (rv !== 1'b1 && n < 64);
		rd = rdata;
		rs = rresp;
		rr <= 1'b0;
		chk(32'(n < 64), 32'h1);
		@(posedge aclk);
		chk(rd, exp);
	endtask

	// protocol numbers, first in the low byte; all within 0 or 1 to 128;
	// written only while idle, so a running chain never sees them change
	task automatic setp(input logic [63:0] p);
		for (int i = 0; i < 8; i++)
			wr(`PPS_ADDR_PROTO0 + 16'(4 * i), {24'h0, p[8 * i +: 8]});
	endtask

	task automatic slots(input logic [63:0] s);
		for (int i = 0; i < 8; i++)
			rdc(`PPS_ADDR_SLOT0 + 16'(4 * i), {24'h0, s[8 * i +: 8]});
	endtask

	task automatic cmd(input logic [4:0] k, input logic [3:0] c);
		xcon = k;
		q.delete();
		aborts = 0;
		wr(`PPS_ADDR_CMD, {1'b1, 19'h0, c, 3'h0, k});
	endtask

	// wait for completion, then time the flag interval against the scan period
	task automatic fin(input logic e);
		int n;
		n = 0;
		while (done !== 1'b1 && n < 3000) begin
			@(posedge aclk);
			n++;
		end
		chk({31'h0, errf}, {31'h0, e});
		n = 0;
		while (done === 1'b1 && n < 100) begin
			@(posedge aclk);
			n++;
		end
		chk(32'(n), 32'h10);
		chk({30'h0, errf, busy}, 32'h0);
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// --------------------------------------------------------
	// scenarios
	// --------------------------------------------------------
	task automatic t_chain();
		rdc(`PPS_ADDR_OPEN, `PPS_OPEN_RST);
		chk({16'h0, lref}, 32'h0);
		rdc(16'h0100, 32'h0);
		chk({30'h0, rs}, {30'h0, `PPS_RESP_SLVERR});
		wr(16'h0100, 32'h0);
		chk({30'h0, rs}, {30'h0, `PPS_RESP_SLVERR});
		wr(`PPS_ADDR_OPEN, 32'hFFFFFFD2);
		chk({30'h0, rs}, {30'h0, `PPS_RESP_OKAY});
		chk({16'h0, lref}, 32'h7);
		setp(64'h2A1305);
		cmd(5'h01, 4'h3);
		chk({30'h0, cu}, 32'h2);
		wr(`PPS_ADDR_CMD, 32'h80000101);
		fin(1'b0);
		chk({8'h00, q[0], q[1], q[2]}, 32'h05132A);
		chk(32'(q.size()), 32'h3);
		rdc(`PPS_ADDR_COUNT, 32'h3);
		rdc(`PPS_ADDR_CSTAT, 32'h0);
		slots(64'h0B0400);
	endtask

	task automatic t_fail();
		setp(64'h120711);
		fnum <= 8'h07;
		cmd(5'h01, 4'h3);
		fin(1'b1);
		chk(32'(q.size()), 32'h2);
		rdc(`PPS_ADDR_COUNT, 32'h2);
		rdc(`PPS_ADDR_CSTAT, 32'hC4A1);
		slots(64'h02);
		fnum <= 8'h00;
	endtask

	task automatic t_send();
		lat <= 8'h01;
		setp(64'h0807060504030201);
		cmd(5'h02, 4'h8);
		fin(1'b0);
		chk(32'(q.size()), 32'h8);
		rdc(`PPS_ADDR_COUNT, 32'h8);
		slots(64'h0);
		setp(64'h11);
		cmd(5'h02, 4'h1);
		fin(1'b1);
		chk(32'(q.size()), 32'h0);
		rdc(`PPS_ADDR_CSTAT, {16'h0, `PPS_ERR_CONN});
		rdc(`PPS_ADDR_COUNT, 32'h0);
	endtask

	task automatic t_cancel();
		hold <= 1'b1;
		setp(64'h15);
		cmd(5'h03, 4'h1);
		repeat (200) @(posedge aclk);
		chk({30'h0, done, busy}, 32'h1);
		chk({14'h0, cu, lref}, 32'h10007);
		rdc(`PPS_ADDR_AREA_LO, 32'h3);
		swd <= 1'b1;
		@(posedge aclk);
		swd <= 1'b0;
		fin(1'b1);
		chk(32'(aborts), 32'h1);
		rdc(`PPS_ADDR_CSTAT, {16'h0, `PPS_ERR_SETWR});
		rdc(`PPS_ADDR_COUNT, 32'h1);
		hold <= 1'b0;
		setp(64'h01);
		cmd(5'h01, 4'h9);
		fin(1'b1);
		rdc(`PPS_ADDR_CSTAT, {16'h0, `PPS_ERR_CTRL});
		rdc(`PPS_ADDR_COUNT, 32'h0);
	endtask

	// --------------------------------------------------------
	// main sequence and watchdog
	// --------------------------------------------------------
	initial begin
		{awv, wv, br, arv, rr, swd, hold} = 7'h00;
		awa = 16'h0000;
		ara = 16'h0000;
		wd = 32'h0;
		ws = 4'hF;
		lat = 8'h14;
		fnum = 8'h00;
		xcon = 5'h00;
		n_errors = 0;
		num_checks = 0;
		aresetn = 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rdc(`PPS_ADDR_FLAGS, 32'h0);
		t_chain();
		t_fail();
		t_send();
		t_cancel();
		close_out();
	end

	// the scenarios need well under 20000 cycles
	initial begin
		#300000;
		n_errors++;
		$display("[FAIL] %0t watchdog ran out", $time);
		close_out();
	end
endmodule
`default_nettype wire

// ### verilog/pps_defs.svh
// constants of the protocol chain sequencer: register offsets, field positions, codes
// assumes nothing; included by the bench and the sequencer
`ifndef PPS_DEFS_SVH
`define PPS_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PPS_ADDR_CMD 16'h0000
`define PPS_ADDR_FLAGS 16'h0004
`define PPS_ADDR_COUNT 16'h0008
`define PPS_ADDR_CSTAT 16'h000C
`define PPS_ADDR_PROTO0 16'h0010
`define PPS_ADDR_PROTO7 16'h002C
`define PPS_ADDR_SLOT0 16'h0030
`define PPS_ADDR_SLOT7 16'h004C
`define PPS_ADDR_OPEN 16'h0050
`define PPS_ADDR_AREA_LO 16'h54C0
`define PPS_ADDR_AREA_IDX 16'h54C4
`define PPS_ADDR_AREA_HI 16'h55FF

// ----------------------------------------------------------------
// fields, limits, reset values
// ----------------------------------------------------------------
`define PPS_CMD_START_BIT 31
`define PPS_CMD_CONN_LSB 0
`define PPS_CMD_CNT_LSB 8
`define PPS_MAX_PROTO 4'h8
`define PPS_PROTO_MAX 8'h80
`define PPS_CONN_MAX 5'h10
`define PPS_OPEN_RST 32'hFFFFFFFF

// ----------------------------------------------------------------
// completion codes, communication types, open modes, bus answers
// ----------------------------------------------------------------
`define PPS_ERR_OK 16'h0000
`define PPS_ERR_CONN 16'hC407
`define PPS_ERR_SETWR 16'hC430
`define PPS_ERR_CTRL 16'hC4F0
`define PPS_TYPE_SEND 2'h0
`define PPS_TYPE_RECV 2'h1
`define PPS_TYPE_BOTH 2'h2
`define PPS_OPEN_SEND 2'h0
`define PPS_OPEN_RECV 2'h1
`define PPS_OPEN_PAIR 2'h2
`define PPS_RESP_OKAY 2'h0
`define PPS_RESP_SLVERR 2'h2

`endif

// ### verilog/pps_pkg.sv
// types of the protocol chain sequencer
// assumes nothing; does not include pps_defs.svh
`default_nettype none

package pps_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CHECK,
		ST_LAUNCH,
		ST_WAIT,
		ST_POST,
		ST_HOLD
	} pps_state_t;

	// every flip-flop of the sequencer, registered as one word
	typedef struct packed {
		pps_state_t st;
		logic [4:0] conn;
		logic [3:0] cnt;
		logic [2:0] idx;
		logic snd;
		logic rcv;
		logic both;
		logic [7:0][7:0] proto;
		logic [7:0][4:0] slot;
		logic [3:0] exec_cnt;
		logic [15:0] cstat;
		logic [31:0] open;
		logic done;
		logic err;
		logic eng_start;
		logic eng_abort;
		logic aw_v;
		logic [15:0] aw_a;
		logic w_v;
		logic [31:0] w_d;
		logic [3:0] w_s;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} pps_regs_t;

endpackage

`default_nettype wire

// ### verilog/pps_sequencer.sv
// protocol chain sequencer: AXI4-Lite registers, chain checker, run loop, scan-end flags
// assumes one 100 MHz clock, a protocol engine and a type table on the same clock
//
// Functional notes
// - receive-type protocol stores its matched packet number, 1 to 16, in its slot
// - send-only protocol writes zero into its slot
// - failed protocol and slots beyond the executed count read zero
// - one command runs up to eight protocols back to back on the named connection
// - protocols run in the order of the listed protocol numbers
// - a command arriving while one is still running is ignored
// - executed protocol count is written into the first control word
// - live execution status readable in the area 54C0h to 55FFh
// - all send-only needs send or paired open; all receive-only needs receive or paired
// - either paired connection is accepted; pairing uses one extra connection
// - done flag rises at the completing scan end, falls at the next one
// - error flag stays low on success, pulses with done on abnormal end
// - a failing protocol skips the rest and ends the command abnormally
// - predefined-protocol connection refuses command-response, fixed and random buffers
// - dedicated-connection functions keep running during a chain
// - issuer keeps long raw variables unchanged until the command completes
// - setting write during execution cancels with C430h and abnormal end
// - open setting mismatch reports C407h and ends abnormally
// - zero receive wait time waits forever for the expected data
// - second control word holds 0000h or the last protocol's error code
// - count includes the failed protocol; zero when control data invalid
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "pps_defs.svh"

module pps_sequencer (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [15:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic scan_end,
	input wire logic setting_wr_done,
	output logic [7:0] type_num,
	input wire logic [1:0] type_in,
	output logic eng_start,
	output logic eng_abort,
	output logic [7:0] eng_proto_num,
	output logic [4:0] eng_conn,
	input wire logic eng_done,
	input wire logic [15:0] eng_err,
	input wire logic [4:0] eng_match,
	input wire logic [2:0] eng_phase,
	output logic done_flag,
	output logic err_flag,
	output logic busy,
	output logic [15:0] legacy_refuse,
	output logic [1:0] conns_used
);

	pps_pkg::pps_regs_t s_q;
	pps_pkg::pps_regs_t s_d;

	// ----------------------------------------------------------------
	// derived signals
	// ----------------------------------------------------------------
	logic [1:0] open_mode;
	logic wr_go;
	logic cmd_wr;
	logic last_one;
	logic conn_ok;

	// open mode of the selected connection, two bits per connection
	assign open_mode = s_q.open[{s_q.conn[3:0] - 4'h1, 1'b0} +: 2];
	assign wr_go = s_q.aw_v && s_q.w_v && !s_q.bvalid;
	assign cmd_wr = wr_go && (s_q.aw_a == `PPS_ADDR_CMD) && s_q.w_d[`PPS_CMD_START_BIT];
	assign last_one = ({1'b0, s_q.idx} + 4'h1) == s_q.cnt;
	// paired open takes anything; plain send or receive takes only uniform chains
	assign conn_ok = (open_mode == `PPS_OPEN_PAIR)
		|| (open_mode == `PPS_OPEN_SEND && !s_q.rcv && !s_q.both)
		|| (open_mode == `PPS_OPEN_RECV && !s_q.snd && !s_q.both);

	// type lookup follows the protocol in hand, both while checking and running;
	// numbers are read live, so the issuer must leave them alone until completion
	assign type_num = s_q.proto[s_q.idx];
	assign eng_proto_num = s_q.proto[s_q.idx];
	assign eng_conn = s_q.conn;
	assign eng_start = s_q.eng_start;
	assign eng_abort = s_q.eng_abort;
	assign done_flag = s_q.done;
	assign err_flag = s_q.err;
	assign busy = s_q.st != pps_pkg::ST_IDLE;
	assign conns_used = (busy && open_mode == `PPS_OPEN_PAIR) ? 2'h2 : {1'b0, busy};

	// ----------------------------------------------------------------
	// legacy traffic refusal per connection
	// ----------------------------------------------------------------
	// any connection set up for predefined protocols is closed to other buffer traffic;
	// dedicated-connection services are not gated here at all
	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_refuse
			assign legacy_refuse[g] = s_q.open[2*g +: 2] != 2'h3;
		end
	endgenerate

	// ----------------------------------------------------------------
	// bus handshakes
	// ----------------------------------------------------------------
	assign s_axi_awready = !s_q.aw_v;
	assign s_axi_wready = !s_q.w_v;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rresp = s_q.rresp;
	assign s_axi_rdata = s_q.rdata;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.eng_start = 1'b0;
		s_d.eng_abort = 1'b0;

		// write channel: address and data land in either order, then one response
		if (s_axi_awvalid && !s_q.aw_v) begin
			s_d.aw_v = 1'b1;
			s_d.aw_a = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_q.w_v) begin
			s_d.w_v = 1'b1;
			s_d.w_d = s_axi_wdata;
			s_d.w_s = s_axi_wstrb;
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		if (wr_go) begin
			s_d.aw_v = 1'b0;
			s_d.w_v = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = `PPS_RESP_OKAY;
			if (s_q.aw_a >= `PPS_ADDR_PROTO0 && s_q.aw_a <= `PPS_ADDR_PROTO7
				&& s_q.aw_a[1:0] == 2'h0) begin
				if (s_q.w_s[0]) begin
					s_d.proto[s_q.aw_a[4:2] - 3'h4] = s_q.w_d[7:0];
				end
			end else if (s_q.aw_a == `PPS_ADDR_OPEN) begin
				for (int b = 0; b < 4; b++) begin
					if (s_q.w_s[b]) begin
						s_d.open[8*b +: 8] = s_q.w_d[8*b +: 8];
					end
				end
			end else if (s_q.aw_a != `PPS_ADDR_CMD) begin
				s_d.bresp = `PPS_RESP_SLVERR;
			end
		end

		// read channel: one registered answer per address
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !s_q.rvalid) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = `PPS_RESP_OKAY;
			s_d.rdata = 32'h00000000;
			if (s_axi_araddr == `PPS_ADDR_CMD) begin
				s_d.rdata = {20'h00000, s_q.cnt, 3'h0, s_q.conn};
			end else if (s_axi_araddr == `PPS_ADDR_FLAGS) begin
				s_d.rdata = {26'h0, conns_used, 1'b0, s_q.err, s_q.done, busy};
			end else if (s_axi_araddr == `PPS_ADDR_COUNT) begin
				s_d.rdata = {28'h0000000, s_q.exec_cnt};
			end else if (s_axi_araddr == `PPS_ADDR_CSTAT) begin
				s_d.rdata = {16'h0000, s_q.cstat};
			end else if (s_axi_araddr >= `PPS_ADDR_PROTO0 && s_axi_araddr <= `PPS_ADDR_PROTO7) begin
				s_d.rdata = {24'h000000, s_q.proto[s_axi_araddr[4:2] - 3'h4]};
			end else if (s_axi_araddr >= `PPS_ADDR_SLOT0 && s_axi_araddr <= `PPS_ADDR_SLOT7) begin
				s_d.rdata = {27'h0, s_q.slot[s_axi_araddr[4:2] - 3'h4]};
			end else if (s_axi_araddr == `PPS_ADDR_OPEN) begin
				s_d.rdata = s_q.open;
			end else if (s_axi_araddr == `PPS_ADDR_AREA_LO) begin
				s_d.rdata = {29'h0, busy ? eng_phase : 3'h0};
			end else if (s_axi_araddr == `PPS_ADDR_AREA_IDX) begin
				s_d.rdata = {25'h0, s_q.st, 1'b0, s_q.idx};
			end else if (s_axi_araddr < `PPS_ADDR_AREA_LO || s_axi_araddr > `PPS_ADDR_AREA_HI) begin
				s_d.rresp = `PPS_RESP_SLVERR;
			end
		end

		// sequencer
		unique case (s_q.st)
			pps_pkg::ST_IDLE: begin
				// only an idle sequencer takes a command
				if (cmd_wr) begin
					s_d.conn = s_q.w_d[`PPS_CMD_CONN_LSB +: 5];
					s_d.cnt = s_q.w_d[`PPS_CMD_CNT_LSB +: 4];
					s_d.idx = 3'h0;
					s_d.snd = 1'b0;
					s_d.rcv = 1'b0;
					s_d.both = 1'b0;
					s_d.slot = '0;
					s_d.exec_cnt = 4'h0;
					s_d.cstat = `PPS_ERR_OK;
					s_d.st = pps_pkg::ST_CHECK;
				end
			end
			pps_pkg::ST_CHECK: begin
				// bad control data stops before any protocol runs, count stays zero
				if (s_q.cnt == 4'h0 || s_q.cnt > `PPS_MAX_PROTO || s_q.conn == 5'h00
					|| s_q.conn > `PPS_CONN_MAX || type_num == 8'h00
					|| type_num > `PPS_PROTO_MAX) begin
					s_d.cstat = `PPS_ERR_CTRL;
					s_d.st = pps_pkg::ST_POST;
				end else begin
					s_d.snd = s_q.snd || (type_in == `PPS_TYPE_SEND);
					s_d.rcv = s_q.rcv || (type_in == `PPS_TYPE_RECV);
					s_d.both = s_q.both || (type_in == `PPS_TYPE_BOTH);
					s_d.idx = s_q.idx + 3'h1;
					if (last_one) begin
						s_d.idx = 3'h0;
						s_d.st = pps_pkg::ST_LAUNCH;
					end
				end
			end
			pps_pkg::ST_LAUNCH: begin
				// types are now gathered: refuse the whole chain on a mismatched open
				if (s_q.idx == 3'h0 && !conn_ok) begin
					s_d.cstat = `PPS_ERR_CONN;
					s_d.st = pps_pkg::ST_POST;
				end else begin
					s_d.eng_start = 1'b1;
					s_d.st = pps_pkg::ST_WAIT;
				end
			end
			pps_pkg::ST_WAIT: begin
				// no timeout: a zero wait time protocol may hold here forever
				if (setting_wr_done) begin
					s_d.eng_abort = 1'b1;
					s_d.exec_cnt = s_q.exec_cnt + 4'h1;
					s_d.cstat = `PPS_ERR_SETWR;
					s_d.st = pps_pkg::ST_POST;
				end else if (eng_done) begin
					s_d.exec_cnt = s_q.exec_cnt + 4'h1;
					if (eng_err != `PPS_ERR_OK) begin
						s_d.cstat = eng_err;
						s_d.st = pps_pkg::ST_POST;
					end else begin
						if (type_in != `PPS_TYPE_SEND) begin
							s_d.slot[s_q.idx] = eng_match;
						end
						if (last_one) begin
							s_d.cstat = `PPS_ERR_OK;
							s_d.st = pps_pkg::ST_POST;
						end else begin
							s_d.idx = s_q.idx + 3'h1;
							s_d.st = pps_pkg::ST_LAUNCH;
						end
					end
				end
			end
			pps_pkg::ST_POST: begin
				if (scan_end) begin
					s_d.done = 1'b1;
					s_d.err = s_q.cstat != `PPS_ERR_OK;
					s_d.st = pps_pkg::ST_HOLD;
				end
			end
			pps_pkg::ST_HOLD: begin
				if (scan_end) begin
					s_d.done = 1'b0;
					s_d.err = 1'b0;
					s_d.st = pps_pkg::ST_IDLE;
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// slots hold zero except where a receive match was stored, so send-only,
	// failed and unexecuted positions need no separate clearing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
			s_q.st <= pps_pkg::ST_IDLE;
			s_q.open <= `PPS_OPEN_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_clear_start;
		s_q.st == pps_pkg::ST_IDLE && cmd_wr |=> s_q.slot == '0 && s_q.exec_cnt == 4'h0;
	endproperty
	a_clear_start: assert property (p_clear_start) else $error("slots not cleared at start");

	property p_ignore_busy;
		busy && cmd_wr |=> $stable(s_q.conn) && $stable(s_q.cnt);
	endproperty
	a_ignore_busy: assert property (p_ignore_busy) else $error("command taken while busy");

	property p_done_fall;
		done_flag && scan_end |=> !done_flag && !err_flag;
	endproperty
	a_done_fall: assert property (p_done_fall) else $error("done not cleared at next scan end");

	property p_err_with_done;
		$rose(done_flag) |-> err_flag == (s_q.cstat != `PPS_ERR_OK) ##1 err_flag == $past(err_flag);
	endproperty
	a_err_with_done: assert property (p_err_with_done) else $error("error flag not tied to done");

	property p_setwr;
		s_q.st == pps_pkg::ST_WAIT && setting_wr_done |=> eng_abort && s_q.cstat == `PPS_ERR_SETWR;
	endproperty
	a_setwr: assert property (p_setwr) else $error("setting write did not cancel");

	property p_conn_err;
		s_q.st == pps_pkg::ST_LAUNCH && s_q.idx == 3'h0 && !conn_ok
		|=> s_q.st == pps_pkg::ST_POST && s_q.cstat == `PPS_ERR_CONN && !eng_start;
	endproperty
	a_conn_err: assert property (p_conn_err) else $error("open mismatch not refused");

	property p_fail_skip;
		s_q.st == pps_pkg::ST_WAIT && !setting_wr_done && eng_done && eng_err != `PPS_ERR_OK
		|=> s_q.st == pps_pkg::ST_POST ##1 !eng_start;
	endproperty
	a_fail_skip: assert property (p_fail_skip) else $error("chain went on after failure");

	property p_slot_zero;
		s_q.st == pps_pkg::ST_WAIT && eng_done && (eng_err != `PPS_ERR_OK || type_in == `PPS_TYPE_SEND)
		|=> s_q.slot[$past(s_q.idx)] == 5'h00;
	endproperty
	a_slot_zero: assert property (p_slot_zero) else $error("slot not zero");

	property p_slot_match;
		s_q.st == pps_pkg::ST_WAIT && !setting_wr_done && eng_done && eng_err == `PPS_ERR_OK
		&& type_in != `PPS_TYPE_SEND |=> s_q.slot[$past(s_q.idx)] == $past(eng_match);
	endproperty
	a_slot_match: assert property (p_slot_match) else $error("match number not stored");

	property p_count_max;
		s_q.exec_cnt <= `PPS_MAX_PROTO;
	endproperty
	a_count_max: assert property (p_count_max) else $error("more than eight executed");

	c_normal: cover property ($rose(done_flag) && !err_flag);
	c_abnormal: cover property ($rose(err_flag));
	c_cancel: cover property (s_q.st == pps_pkg::ST_WAIT && setting_wr_done);
	c_chain8: cover property ($rose(done_flag) && s_q.exec_cnt == 4'h8);

endmodule

`default_nettype wire
